// ---- iris_actuator_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module iris_actuator_model (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst_b,
  // drive from the iris control
  input  wire logic [7:0] iris_position,
  input  wire logic       iris_auto_mode,
  // moves seen, for the bench
  output logic      [7:0] moves
);
  logic [7:0] last_pos;
  // settles at once; a real stepper would lag the commanded position
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      last_pos <= 8'h00;
      moves    <= 8'h00;
    end else begin
      last_pos <= iris_position;
      if (last_pos != iris_position) begin
        moves <= moves + 8'h01;
      end
    end
  end
endmodule : iris_actuator_model
`default_nettype wire

// ---- iris_pkg.sv ----
// What this block does
// [RULE1] 8-bit step size is the increment of every single-step command
// [RULE2] close-step write closes one step; close-full write closes fully; data ignored
// [RULE3] open-step write opens one step; open-full write opens fully; data ignored
// [RULE4] state register low byte shows the current iris position
// [RULE5] state register bytes 15:8 and 23:16 always read zero
// [RULE6] state register top byte shows the maximum iris position
// [RULE7] 8-bit read-write maximum step count resets to 73
// [RULE8] enable bit 0 selects manual (0) or automatic regulation (1)
// [RULE9] automatic regulation keeps position between lower and upper limits
// [RULE10] step commands saturate at zero and at the maximum count
// [RULE11] saved position is an 8-bit value read back unchanged
package iris_pkg;
  localparam logic [15:0] OFF_LOWER_LIMIT = 16'h0170;
  localparam logic [15:0] OFF_UPPER_LIMIT = 16'h0174;
  localparam logic [15:0] OFF_AUTO_EN     = 16'h017C;
  localparam logic [15:0] OFF_SAVED_POS   = 16'h0400;
  localparam logic [15:0] OFF_MAX_COUNT   = 16'h0404;
  localparam logic [15:0] OFF_STEP_SIZE   = 16'h6200;
  localparam logic [15:0] OFF_CLOSE_STEP  = 16'h6204;
  localparam logic [15:0] OFF_OPEN_STEP   = 16'h6208;
  localparam logic [15:0] OFF_CLOSE_FULL  = 16'h620C;
  localparam logic [15:0] OFF_OPEN_FULL   = 16'h6210;
  localparam logic [15:0] OFF_STATE       = 16'h6258;

  localparam logic [7:0]  RST_MAX_COUNT   = 8'h49;
  localparam logic [7:0]  RST_STEP_SIZE   = 8'h01;
  localparam logic [7:0]  RST_LOWER_LIMIT = 8'h00;
  localparam logic [7:0]  RST_UPPER_LIMIT = 8'h49;
  localparam int          AUTO_EN_BIT     = 0;
  localparam int          POS_LSB         = 0;
  localparam int          MAX_LSB         = 24;
endpackage : iris_pkg

// ---- iris_pos_calc.sv ----
`timescale 1ns/1ps
`default_nettype none
module iris_pos_calc (
  // current state and controls
  input  wire logic [7:0] pos,
  input  wire logic [7:0] step,
  input  wire logic [7:0] max_cnt,
  // commands
  input  wire logic       close_step,
  input  wire logic       open_step,
  input  wire logic       close_full,
  input  wire logic       open_full,
  // automatic regulation
  input  wire logic       auto_en,
  input  wire logic [7:0] lo_lim,
  input  wire logic [7:0] hi_lim,
  // result
  output logic      [7:0] pos_next
);
  // larger position = more closed; the 9-bit sum catches overflow
  wire logic [8:0] up_sum   = {1'b0, pos} + {1'b0, step};
  wire logic [7:0] up_sat   = (up_sum > {1'b0, max_cnt}) ? max_cnt : up_sum[7:0]; // [RULE10]
  wire logic [7:0] down_sat = (step > pos) ? 8'h00 : pos - step;                 // [RULE10]
  wire logic [7:0] cmd_pos  = close_full ? max_cnt :                             // [RULE2]
                              open_full  ? 8'h00 :                               // [RULE3]
                              close_step ? up_sat :                              // [RULE1]
                              open_step  ? down_sat : pos;
  // upper limit of auto mode also clipped to the mechanical maximum
  wire logic [7:0] hi_eff   = (hi_lim > max_cnt) ? max_cnt : hi_lim;
  wire logic [7:0] lo_clip  = (cmd_pos < lo_lim) ? lo_lim : cmd_pos;
  wire logic [7:0] auto_pos = (lo_clip > hi_eff) ? hi_eff : lo_clip;
  assign pos_next = auto_en ? auto_pos : cmd_pos;                                // [RULE8] [RULE9]
endmodule : iris_pos_calc
`default_nettype wire

// ---- stepped_iris_control.sv ----
// Local design decision: the APB register port.
`timescale 1ns/1ps
`default_nettype none
module stepped_iris_control (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst_b,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [15:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // actuator side
  output logic      [7:0]  iris_position,
  output logic             iris_auto_mode
);
  // ---------------------------------------------------------------
  // register storage
  // ---------------------------------------------------------------
  logic [7:0]  step_reg, max_reg, saved_reg, lo_reg, hi_reg, pos_reg;
  logic        auto_reg;
  logic [31:0] rdata_reg;
  logic        err_reg;
  logic [7:0]  pos_next;

  // ---------------------------------------------------------------
  // decode
  // ---------------------------------------------------------------
  function automatic logic hit(input logic [15:0] a, input logic [15:0] off);
    hit = (a == off);
  endfunction : hit

  wire logic setup   = psel & ~penable;
  wire logic wr_take = setup & pwrite;
  wire logic rd_take = setup & ~pwrite;
  wire logic w_step  = wr_take & hit(paddr, iris_pkg::OFF_STEP_SIZE);
  wire logic w_max   = wr_take & hit(paddr, iris_pkg::OFF_MAX_COUNT);
  wire logic w_saved = wr_take & hit(paddr, iris_pkg::OFF_SAVED_POS);
  wire logic w_lo    = wr_take & hit(paddr, iris_pkg::OFF_LOWER_LIMIT);
  wire logic w_hi    = wr_take & hit(paddr, iris_pkg::OFF_UPPER_LIMIT);
  wire logic w_auto  = wr_take & hit(paddr, iris_pkg::OFF_AUTO_EN);
  // command writes: data is a don't-care
  wire logic c_cs    = wr_take & hit(paddr, iris_pkg::OFF_CLOSE_STEP);   // [RULE2]
  wire logic c_os    = wr_take & hit(paddr, iris_pkg::OFF_OPEN_STEP);    // [RULE3]
  wire logic c_cf    = wr_take & hit(paddr, iris_pkg::OFF_CLOSE_FULL);   // [RULE2]
  wire logic c_of    = wr_take & hit(paddr, iris_pkg::OFF_OPEN_FULL);    // [RULE3]
  wire logic w_known = w_step | w_max | w_saved | w_lo | w_hi | w_auto | c_cs | c_os | c_cf | c_of;

  wire logic [31:0] state_word = {max_reg, 8'h00, 8'h00, pos_reg};  // [RULE4] [RULE5] [RULE6]
  logic [31:0] rd_mux;
  logic        rd_ok;
  always_comb begin
    rd_ok  = 1'b1;
    rd_mux = 32'h0000_0000;
    unique case (paddr)
      iris_pkg::OFF_STEP_SIZE:   rd_mux = {24'h000000, step_reg};   // [RULE1]
      iris_pkg::OFF_MAX_COUNT:   rd_mux = {24'h000000, max_reg};    // [RULE7]
      iris_pkg::OFF_SAVED_POS:   rd_mux = {24'h000000, saved_reg};  // [RULE11]
      iris_pkg::OFF_LOWER_LIMIT: rd_mux = {24'h000000, lo_reg};
      iris_pkg::OFF_UPPER_LIMIT: rd_mux = {24'h000000, hi_reg};
      iris_pkg::OFF_AUTO_EN:     rd_mux = {31'h00000000, auto_reg};
      iris_pkg::OFF_STATE:       rd_mux = state_word;
      default:                   rd_ok  = 1'b0;
    endcase
  end

  // ---------------------------------------------------------------
  // position arithmetic
  // ---------------------------------------------------------------
  iris_pos_calc u_calc (
    .pos        (pos_reg),
    .step       (step_reg),
    .max_cnt    (max_reg),
    .close_step (c_cs),
    .open_step  (c_os),
    .close_full (c_cf),
    .open_full  (c_of),
    .auto_en    (auto_reg),
    .lo_lim     (lo_reg),
    .hi_lim     (hi_reg),
    .pos_next   (pos_next)
  );

  // ---------------------------------------------------------------
  // registers; one-cycle answer: setup takes, access ends
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      step_reg  <= iris_pkg::RST_STEP_SIZE;
      max_reg   <= iris_pkg::RST_MAX_COUNT;      // [RULE7]
      saved_reg <= 8'h00;
      lo_reg    <= iris_pkg::RST_LOWER_LIMIT;
      hi_reg    <= iris_pkg::RST_UPPER_LIMIT;
      auto_reg  <= 1'b0;
      pos_reg   <= 8'h00;
    end else begin
      if (w_step)  step_reg  <= pwdata[7:0];   // [RULE1]
      if (w_max)   max_reg   <= pwdata[7:0];   // [RULE7]
      if (w_saved) saved_reg <= pwdata[7:0];   // [RULE11]
      if (w_lo)    lo_reg    <= pwdata[7:0];   // [RULE9]
      if (w_hi)    hi_reg    <= pwdata[7:0];   // [RULE9]
      if (w_auto)  auto_reg  <= pwdata[iris_pkg::AUTO_EN_BIT];  // [RULE8]
      pos_reg <= pos_next;                     // [RULE4]
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rdata_reg <= 32'h0000_0000;
      err_reg   <= 1'b0;
    end else if (setup) begin
      rdata_reg <= rd_take ? rd_mux : 32'h0000_0000;
      err_reg   <= rd_take ? ~rd_ok : ~w_known;
    end
  end

  assign prdata         = rdata_reg;
  assign pready         = 1'b1;
  assign pslverr        = psel & penable & err_reg;
  assign iris_position  = pos_reg;
  assign iris_auto_mode = auto_reg;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  a_state_zero_bytes: assert property (@(posedge clk) disable iff (!rst_b) // [RULE5]
    (psel && penable && !pwrite && paddr == iris_pkg::OFF_STATE) |-> prdata[23:8] == 16'h0000)
    else $error("state middle bytes not zero");
  a_pos_in_range: assert property (@(posedge clk) disable iff (!rst_b) // [RULE10]
    $past(pos_next) <= max_reg || $changed(max_reg))
    else $error("position beyond maximum");
  a_close_full_max: assert property (@(posedge clk) disable iff (!rst_b) // [RULE2]
    (c_cf && !auto_reg) |=> pos_reg == $past(max_reg))
    else $error("close full missed maximum");
  a_open_full_zero: assert property (@(posedge clk) disable iff (!rst_b) // [RULE3]
    (c_of && !auto_reg) |=> pos_reg == 8'h00)
    else $error("open full not zero");
  a_open_step_dec: assert property (@(posedge clk) disable iff (!rst_b) // [RULE1]
    (c_os && !auto_reg && pos_reg >= step_reg) |=> pos_reg == $past(pos_reg) - $past(step_reg))
    else $error("open step wrong amount");
  a_manual_hold: assert property (@(posedge clk) disable iff (!rst_b) // [RULE8]
    (!auto_reg && !c_cs && !c_os && !c_cf && !c_of) |=> $stable(pos_reg))
    else $error("manual position moved alone");
  a_auto_limits: assert property (@(posedge clk) disable iff (!rst_b) // [RULE9]
    (auto_reg && lo_reg <= hi_reg && hi_reg <= max_reg && $stable(lo_reg) && $stable(hi_reg))
      |=> (pos_reg >= lo_reg && pos_reg <= hi_reg))
    else $error("auto position outside limits");
  a_state_top_max: assert property (@(posedge clk) disable iff (!rst_b) // [RULE6]
    (psel && penable && !pwrite && paddr == iris_pkg::OFF_STATE) |-> prdata[31:24] == max_reg)
    else $error("state top byte not maximum");
  a_saved_readback: assert property (@(posedge clk) disable iff (!rst_b) // [RULE11]
    (rd_take && paddr == iris_pkg::OFF_SAVED_POS)
      |=> prdata == {24'h000000, $past(saved_reg)})
    else $error("saved position changed");
endmodule : stepped_iris_control
`default_nettype wire

// ---- stepped_iris_control_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module stepped_iris_control_tb;
  logic        clk = 1'b0, rst_b = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [15:0] paddr = 16'h0000;
  logic [31:0] pwdata = 32'h0000_0000, prdata;
  logic        pready, pslverr, auto_mode;
  logic [7:0]  pos, moves;
  int          num_errors = 0, compares = 0;
  stepped_iris_control i_dut (.clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .iris_position(pos), .iris_auto_mode(auto_mode));
  iris_actuator_model i_act (.clk(clk), .rst_b(rst_b), .iris_position(pos),
    .iris_auto_mode(auto_mode), .moves(moves));
  initial begin
    forever #4 clk = ~clk;
  end
  task end_sim;
    $display("errors %0d compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : end_sim
  task chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
    compares++;
    if (got !== ex) begin
      num_errors++;
      $display("wrong value %s exp %h got %h", nm, ex, got);
    end
  endtask : chk
  // one apb transfer; idle edge first so no signal is driven twice in a step
  task apb(input logic wr, input logic [15:0] a, input logic [31:0] d,
           output logic [31:0] r, output logic e);
    int n;
    @(posedge clk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) chk("pready", 32'h1, 32'h0);
    r = prdata;
    e = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask : apb
  task wr(input logic [15:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, r, e);
  endtask : wr
  task rd(input logic [15:0] a, input logic [31:0] ex, input logic erx);
    logic [31:0] r;
    logic        e;
    apb(1'b0, a, 32'h0, r, e);
    chk("prdata", ex, r);
    chk("pslverr", {31'h0, erx}, {31'h0, e});
  endtask : rd
  task t_reset;
    rd(iris_pkg::OFF_MAX_COUNT, 32'h0000_0049, 1'b0);
    rd(iris_pkg::OFF_STATE, 32'h4900_0000, 1'b0);
  endtask : t_reset
  task t_steps;
    wr(iris_pkg::OFF_STEP_SIZE, 32'hFFFF_FF05);
    rd(iris_pkg::OFF_STEP_SIZE, 32'h0000_0005, 1'b0);
    wr(iris_pkg::OFF_CLOSE_STEP, 32'h0);
    wr(iris_pkg::OFF_CLOSE_STEP, 32'hFFFF_FFFF);
    chk("position", 32'h0000_000A, {24'h0, pos});
    wr(iris_pkg::OFF_OPEN_STEP, 32'h0);
    rd(iris_pkg::OFF_STATE, 32'h4900_0005, 1'b0);
  endtask : t_steps
  task t_ends;
    wr(iris_pkg::OFF_CLOSE_FULL, 32'h0);
    chk("position", 32'h49, {24'h0, pos});
    wr(iris_pkg::OFF_CLOSE_STEP, 32'h0);
    chk("position", 32'h49, {24'h0, pos});
    wr(iris_pkg::OFF_OPEN_FULL, 32'h0);
    chk("position", 32'h0, {24'h0, pos});
    wr(iris_pkg::OFF_OPEN_STEP, 32'h0);
    chk("position", 32'h0, {24'h0, pos});
    wr(iris_pkg::OFF_MAX_COUNT, 32'h0000_0020);
    wr(iris_pkg::OFF_CLOSE_FULL, 32'h0);
    rd(iris_pkg::OFF_STATE, 32'h2000_0020, 1'b0);
  endtask : t_ends
  task t_saved_and_refused;
    wr(iris_pkg::OFF_SAVED_POS, 32'hFFFF_FFAB);
    rd(iris_pkg::OFF_SAVED_POS, 32'h0000_00AB, 1'b0);
    rd(iris_pkg::OFF_OPEN_STEP, 32'h0, 1'b1);
    rd(16'h6300, 32'h0, 1'b1);
  endtask : t_saved_and_refused
  task t_auto;
    wr(iris_pkg::OFF_LOWER_LIMIT, 32'h3);
    wr(iris_pkg::OFF_UPPER_LIMIT, 32'h9);
    wr(iris_pkg::OFF_AUTO_EN, 32'hFFFF_FFFF);
    rd(iris_pkg::OFF_AUTO_EN, 32'h1, 1'b0);
    chk("auto mode", 32'h1, {31'h0, auto_mode});
    chk("position", 32'h9, {24'h0, pos});
    wr(iris_pkg::OFF_OPEN_FULL, 32'h0);
    chk("position", 32'h3, {24'h0, pos});
    wr(iris_pkg::OFF_AUTO_EN, 32'h0);
    wr(iris_pkg::OFF_OPEN_STEP, 32'h0);
    chk("position", 32'h0, {24'h0, pos});
  endtask : t_auto
  initial begin
    repeat (5) @(posedge clk);
    rst_b <= 1'b1;
    t_reset();
    t_steps();
    t_ends();
    t_saved_and_refused();
    t_auto();
    chk("moves", 32'h1, {31'h0, moves != 8'h00});
    end_sim();
  end
  initial begin
    repeat (3000) @(posedge clk);
    num_errors++;
    end_sim();
  end
endmodule : stepped_iris_control_tb
`default_nettype wire
